// File: inc/swt_pkg.sv
// Package with the register map, field layout, reset values and types of the wake trim and recovery block.
package swt_pkg;

    // Register word addresses on the register port.
    localparam logic [6:0] ADDR_TRIM = 7'h3c;
    localparam logic [6:0] ADDR_CAL  = 7'h3d;
    localparam logic [6:0] ADDR_CDR  = 7'h3e;

    // Trim register field positions.
    localparam int WAKE_SEL_BIT = 14;
    localparam int TEMP_MSB     = 11;
    localparam int TEMP_LSB     = 7;
    localparam int COARSE_MSB   = 6;
    localparam int COARSE_LSB   = 0;

    // Calibration register field positions.
    localparam int CAL_HI_MSB = 15;
    localparam int CAL_HI_LSB = 8;
    localparam int CAL_LO_MSB = 7;
    localparam int CAL_LO_LSB = 0;

    // Recovery control field positions.
    localparam int CLK_SEL_MSB = 6;
    localparam int CLK_SEL_LSB = 5;
    localparam int FILT_MSB    = 3;
    localparam int FILT_LSB    = 2;
    localparam int EN_BIT      = 0;

    // Unlock code that opens the trim fields.
    localparam logic [1:0] TRIM_UNLOCK = 2'h3;

    // Values after power-on or soft reset.
    localparam logic [15:0] TRIM_RESET    = 16'h0000;
    localparam logic [15:0] CAL_RESET     = 16'h0000;
    localparam logic [15:0] CDR_RESET     = 16'h0004;
    localparam logic [1:0]  CLK_SEL_RESET = 2'h0;
    localparam logic [1:0]  FILT_RESET    = 2'h1;
    localparam logic        EN_RESET      = 1'b0;

    // Filter select codes and the time constants they give.
    localparam logic [1:0] FILT_TC8      = 2'h0;
    localparam logic [1:0] FILT_TC16     = 2'h1;
    localparam logic [1:0] FILT_TC32     = 2'h2;
    localparam logic [1:0] FILT_ADAPTIVE = 2'h3;
    localparam logic [5:0] TC_8          = 6'h08;
    localparam logic [5:0] TC_16         = 6'h10;
    localparam logic [5:0] TC_32         = 6'h20;

    // Falling edge spacing bands, in bit times, for the adaptive filter.
    localparam logic [3:0] GAP_LONG_TC_MIN  = 4'h2;
    localparam logic [3:0] GAP_LONG_TC_MAX  = 4'h3;
    localparam logic [3:0] GAP_MID_TC_MIN   = 4'h4;
    localparam logic [3:0] GAP_MID_TC_MAX   = 4'h8;
    localparam logic [3:0] GAP_SHORT_TC_MIN = 4'h9;
    localparam logic [3:0] GAP_SHORT_TC_MAX = 4'ha;

    // Recovery clock select codes: full, half, quarter and eighth of the base rate.
    localparam logic [1:0] CLK_DIV1 = 2'h0;
    localparam logic [1:0] CLK_DIV2 = 2'h1;
    localparam logic [1:0] CLK_DIV4 = 2'h2;
    localparam logic [1:0] CLK_DIV8 = 2'h3;
    localparam logic [2:0] DIV_CNT_RESET = 3'h0;

    // One register port request.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [6:0]  addr;
        logic [15:0] wdata;
    } swt_req_s;

    // Stored trim fields.
    typedef struct packed {
        logic       wake_receiver_select;
        logic [4:0] temp_coef_trim;
        logic [6:0] oscillator_coarse_trim;
    } swt_trim_s;

    // Stored recovery control fields.
    typedef struct packed {
        logic [1:0] recovery_clock_select;
        logic [1:0] filter_time_constant_select;
        logic       recovery_enable;
    } swt_cdr_s;

endpackage

// File: logic/swt_filter_tc.sv
// Recovery filter time constant selection, fixed or adapted to falling edge spacing.
`timescale 1ns/100ps
module swt_filter_tc (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       soft_reset,
    input  wire logic [1:0] filter_time_constant_select,
    input  wire logic       edge_gap_valid,
    input  wire logic [3:0] edge_gap_bits,
    output logic      [5:0] filter_time_constant
);

    logic [5:0] tc_q;
    logic [5:0] tc_d;

    // Next time constant; the adaptive code keeps its value for gaps outside the bands.
    always_comb
    begin
        tc_d = tc_q;
        if (soft_reset)
        begin
            tc_d = swt_pkg::TC_16;
        end
        else
        begin
            unique case (filter_time_constant_select)
                swt_pkg::FILT_TC8:  tc_d = swt_pkg::TC_8;
                swt_pkg::FILT_TC16: tc_d = swt_pkg::TC_16;
                swt_pkg::FILT_TC32: tc_d = swt_pkg::TC_32;
                swt_pkg::FILT_ADAPTIVE:
                begin
                    if (edge_gap_valid)
                    begin
                        if (edge_gap_bits >= swt_pkg::GAP_LONG_TC_MIN && edge_gap_bits <= swt_pkg::GAP_LONG_TC_MAX)
                            tc_d = swt_pkg::TC_32;
                        else if (edge_gap_bits >= swt_pkg::GAP_MID_TC_MIN && edge_gap_bits <= swt_pkg::GAP_MID_TC_MAX)
                            tc_d = swt_pkg::TC_16;
                        else if (edge_gap_bits >= swt_pkg::GAP_SHORT_TC_MIN
                                 && edge_gap_bits <= swt_pkg::GAP_SHORT_TC_MAX)
                            tc_d = swt_pkg::TC_8;
                    end
                end
            endcase
        end
    end

    // Time constant register.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            tc_q <= swt_pkg::TC_16;
        else
            tc_q <= tc_d;
    end

    assign filter_time_constant = tc_q;

endmodule

// File: logic/swt_osc_trim_cdr.sv
// Wake oscillator trim, calibration status and clock data recovery control registers.
// Operation
// - Reserved bits read zero and ignore writes.
// - Trim bit 14 picks wake receiver: 0 low-power, 1 standard.
// - Wake receiver select is accessible only with unlock code 11.
// - Temperature coefficient trim, bits 11:7, writable only with unlock code 11.
// - Oscillator coarse trim, bits 6:0, writable only with unlock code 11.
// - Trim clears on power-on or soft reset; restart keeps bit 14 and 11:0.
// - Calibration result reads as read-only high and low bytes.
// - Recovery control bits 6:5 select the recovery input clock, read-write.
// - Clock select codes give full, half, quarter and eighth rate.
// - Filter select 00, 01, 10 gives time constant 8, 16, 32.
// - Filter select 11 adapts the time constant to falling edge spacing.
// - Recovery control bit 0 enables the recovery function.
// - Recovery control resets to 0x0004; restart keeps bits 6:5, 3:2, 0.
`timescale 1ns/100ps
module swt_osc_trim_cdr (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              soft_reset,
    input  wire logic              restart,
    input  wire logic [1:0]        trim_unlock,
    input  wire swt_pkg::swt_req_s req,
    input  wire logic              cal_update,
    input  wire logic [15:0]       cal_result,
    input  wire logic              edge_gap_valid,
    input  wire logic [3:0]        edge_gap_bits,
    output logic      [15:0]       rdata,
    output logic                   rdata_valid,
    output logic                   wake_receiver_select,
    output logic      [4:0]        temp_coef_trim,
    output logic      [6:0]        oscillator_coarse_trim,
    output logic                   recovery_enable,
    output logic      [1:0]        recovery_clock_select,
    output logic                   recovery_clock_tick,
    output logic      [5:0]        filter_time_constant
);

    swt_pkg::swt_trim_s trim_q;
    swt_pkg::swt_trim_s trim_d;
    swt_pkg::swt_cdr_s  cdr_q;
    swt_pkg::swt_cdr_s  cdr_d;
    logic [15:0]        cal_q;
    logic [15:0]        cal_d;
    logic [15:0]        rdata_q;
    logic [15:0]        rdata_d;
    logic               rvalid_q;
    logic               rvalid_d;
    logic [2:0]         div_q;
    logic [2:0]         div_d;
    logic [2:0]         div_limit;
    logic               unlocked;
    logic               wr_trim;
    logic               wr_cdr;

    assign unlocked = (trim_unlock == swt_pkg::TRIM_UNLOCK);
    assign wr_trim  = req.wr && (req.addr == swt_pkg::ADDR_TRIM);
    assign wr_cdr   = req.wr && (req.addr == swt_pkg::ADDR_CDR);

    // Next trim fields: soft reset clears, restart keeps, locked writes are dropped.
    always_comb
    begin
        trim_d = trim_q;
        if (soft_reset)
        begin
            trim_d = swt_pkg::swt_trim_s'(swt_pkg::TRIM_RESET[12:0]);
        end
        else if (!restart && wr_trim && unlocked)
        begin
            trim_d.wake_receiver_select   = req.wdata[swt_pkg::WAKE_SEL_BIT];
            trim_d.temp_coef_trim         = req.wdata[swt_pkg::TEMP_MSB:swt_pkg::TEMP_LSB];
            trim_d.oscillator_coarse_trim = req.wdata[swt_pkg::COARSE_MSB:swt_pkg::COARSE_LSB];
        end
    end

    // Next recovery control fields; reserved write bits are simply not stored.
    always_comb
    begin
        cdr_d = cdr_q;
        if (soft_reset)
        begin
            cdr_d.recovery_clock_select       = swt_pkg::CLK_SEL_RESET;
            cdr_d.filter_time_constant_select = swt_pkg::FILT_RESET;
            cdr_d.recovery_enable             = swt_pkg::EN_RESET;
        end
        else if (!restart && wr_cdr)
        begin
            cdr_d.recovery_clock_select       = req.wdata[swt_pkg::CLK_SEL_MSB:swt_pkg::CLK_SEL_LSB];
            cdr_d.filter_time_constant_select = req.wdata[swt_pkg::FILT_MSB:swt_pkg::FILT_LSB];
            cdr_d.recovery_enable             = req.wdata[swt_pkg::EN_BIT];
        end
    end

    // Calibration result capture; restart leaves the last result in place.
    always_comb
    begin
        cal_d = cal_q;
        if (soft_reset)
            cal_d = swt_pkg::CAL_RESET;
        else if (cal_update)
            cal_d = cal_result;
    end

    // Read data, taken on the read strobe and shown one cycle later.
    always_comb
    begin
        rdata_d  = rdata_q;
        rvalid_d = req.rd;
        if (req.rd)
        begin
            rdata_d = '0;
            unique case (req.addr)
                swt_pkg::ADDR_TRIM:
                begin
                    rdata_d[swt_pkg::WAKE_SEL_BIT] = unlocked && trim_q.wake_receiver_select;
                    rdata_d[swt_pkg::TEMP_MSB:swt_pkg::TEMP_LSB]     = trim_q.temp_coef_trim;
                    rdata_d[swt_pkg::COARSE_MSB:swt_pkg::COARSE_LSB] = trim_q.oscillator_coarse_trim;
                end
                swt_pkg::ADDR_CAL:
                begin
                    rdata_d[swt_pkg::CAL_HI_MSB:swt_pkg::CAL_HI_LSB] = cal_q[15:8];
                    rdata_d[swt_pkg::CAL_LO_MSB:swt_pkg::CAL_LO_LSB] = cal_q[7:0];
                end
                swt_pkg::ADDR_CDR:
                begin
                    rdata_d[swt_pkg::CLK_SEL_MSB:swt_pkg::CLK_SEL_LSB] = cdr_q.recovery_clock_select;
                    rdata_d[swt_pkg::FILT_MSB:swt_pkg::FILT_LSB]       = cdr_q.filter_time_constant_select;
                    rdata_d[swt_pkg::EN_BIT]                           = cdr_q.recovery_enable;
                end
                default:
                begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    // Recovery clock divider: one tick every 1, 2, 4 or 8 cycles while enabled.
    always_comb
    begin
        unique case (cdr_q.recovery_clock_select)
            swt_pkg::CLK_DIV1: div_limit = 3'h0;
            swt_pkg::CLK_DIV2: div_limit = 3'h1;
            swt_pkg::CLK_DIV4: div_limit = 3'h3;
            swt_pkg::CLK_DIV8: div_limit = 3'h7;
        endcase
        recovery_clock_tick = cdr_q.recovery_enable && (div_q >= div_limit);
        if (!cdr_q.recovery_enable || recovery_clock_tick)
            div_d = swt_pkg::DIV_CNT_RESET;
        else
            div_d = div_q + 3'h1;
    end

    // State registers; power-on reset loads the documented values.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            trim_q   <= swt_pkg::swt_trim_s'(swt_pkg::TRIM_RESET[12:0]);
            cdr_q    <= swt_pkg::swt_cdr_s'({swt_pkg::CLK_SEL_RESET, swt_pkg::FILT_RESET, swt_pkg::EN_RESET});
            cal_q    <= swt_pkg::CAL_RESET;
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
            div_q    <= swt_pkg::DIV_CNT_RESET;
        end
        else
        begin
            trim_q   <= trim_d;
            cdr_q    <= cdr_d;
            cal_q    <= cal_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            div_q    <= div_d;
        end
    end

    // Filter time constant selection.
    swt_filter_tc u_filter (
        .clock                       (clock),
        .rst                         (rst),
        .soft_reset                  (soft_reset),
        .filter_time_constant_select (cdr_q.filter_time_constant_select),
        .edge_gap_valid              (edge_gap_valid),
        .edge_gap_bits               (edge_gap_bits),
        .filter_time_constant        (filter_time_constant)
    );

    assign rdata                  = rdata_q;
    assign rdata_valid            = rvalid_q;
    assign wake_receiver_select   = trim_q.wake_receiver_select;
    assign temp_coef_trim         = trim_q.temp_coef_trim;
    assign oscillator_coarse_trim = trim_q.oscillator_coarse_trim;
    assign recovery_enable        = cdr_q.recovery_enable;
    assign recovery_clock_select  = cdr_q.recovery_clock_select;

    // Checks on the register behaviour.
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    locked_trim_a: assert property ((wr_trim && !unlocked && !soft_reset) |=> $stable(trim_q))
        else $error("Trim changed by a write while locked.");
    unlocked_write_a: assert property ((wr_trim && unlocked && !soft_reset && !restart)
        |=> oscillator_coarse_trim == $past(req.wdata[6:0]) && temp_coef_trim == $past(req.wdata[11:7]))
        else $error("Unlocked trim write not stored.");
    wake_select_a: assert property ((wr_trim && unlocked && !soft_reset && !restart)
        |=> wake_receiver_select == $past(req.wdata[14]))
        else $error("Wake receiver select not stored.");
    reserved_read_a: assert property ((req.rd && req.addr == swt_pkg::ADDR_CDR)
        |=> rdata_valid && rdata[15:7] == 9'h000 && !rdata[4] && !rdata[1])
        else $error("Reserved recovery bits read nonzero.");
    locked_read_a: assert property ((req.rd && req.addr == swt_pkg::ADDR_TRIM && !unlocked)
        |=> !rdata[14] && !rdata[15] && rdata[13:12] == 2'h0)
        else $error("Locked trim read shows wake select or reserved bits.");
    cal_read_a: assert property ((req.rd && req.addr == swt_pkg::ADDR_CAL) |=> rdata == $past(cal_q))
        else $error("Calibration read mismatch.");
    soft_reset_a: assert property (soft_reset |=> cdr_q == 5'h02 && trim_q == 13'h0000)
        else $error("Soft reset did not load reset values.");
    restart_keep_a: assert property ((restart && !soft_reset) |=> $stable(cdr_q) && $stable(trim_q))
        else $error("Restart changed retained fields.");
    full_rate_a: assert property ((recovery_enable && recovery_clock_select == 2'h0) |-> recovery_clock_tick)
        else $error("Full rate recovery clock missed a tick.");
    eighth_rate_a: assert property ((recovery_clock_tick && recovery_clock_select == 2'h3)
        |=> (!recovery_clock_tick || recovery_clock_select != 2'h3) [*7])
        else $error("Eighth rate recovery clock ticked early.");
    disabled_tick_a: assert property (!recovery_enable |-> !recovery_clock_tick)
        else $error("Recovery clock ticks while disabled.");
    fixed_tc_a: assert property ((cdr_q.filter_time_constant_select == 2'h2 && !soft_reset)
        |=> filter_time_constant == 6'h20)
        else $error("Fixed filter select gave wrong time constant.");
    adaptive_tc_a: assert property ((cdr_q.filter_time_constant_select == 2'h3 && !soft_reset && edge_gap_valid
        && edge_gap_bits >= 4'h9 && edge_gap_bits <= 4'ha) |=> filter_time_constant == 6'h08)
        else $error("Adaptive filter gave wrong time constant.");

    unlock_write_c: cover property (wr_trim && unlocked);
    adaptive_c: cover property (cdr_q.filter_time_constant_select == 2'h3 && edge_gap_valid);
    restart_c: cover property (restart && cdr_q.recovery_enable);
    cal_read_c: cover property (req.rd && req.addr == swt_pkg::ADDR_CAL && cal_q != 16'h0000);

endmodule

// File: sim/testbench.sv
// Self-checking testbench for the wake trim, calibration and recovery control register block.
`timescale 1ns/100ps
module testbench;
    logic              clock;
    logic              rst;
    logic              soft_reset;
    logic              restart;
    logic [1:0]        trim_unlock;
    swt_pkg::swt_req_s req;
    logic              cal_update;
    logic [15:0]       cal_result;
    logic              edge_gap_valid;
    logic [3:0]        edge_gap_bits;
    logic [15:0]       rdata;
    logic              rdata_valid;
    logic              wake_receiver_select;
    logic [4:0]        temp_coef_trim;
    logic [6:0]        oscillator_coarse_trim;
    logic              recovery_enable;
    logic [1:0]        recovery_clock_select;
    logic              recovery_clock_tick;
    logic [5:0]        filter_time_constant;
    int                fail_count;
    int                compares;
    int                c;

    swt_osc_trim_cdr dut (.clock(clock), .rst(rst), .soft_reset(soft_reset), .restart(restart),
        .trim_unlock(trim_unlock), .req(req), .cal_update(cal_update), .cal_result(cal_result),
        .edge_gap_valid(edge_gap_valid), .edge_gap_bits(edge_gap_bits), .rdata(rdata),
        .rdata_valid(rdata_valid), .wake_receiver_select(wake_receiver_select),
        .temp_coef_trim(temp_coef_trim), .oscillator_coarse_trim(oscillator_coarse_trim),
        .recovery_enable(recovery_enable), .recovery_clock_select(recovery_clock_select),
        .recovery_clock_tick(recovery_clock_tick), .filter_time_constant(filter_time_constant));

    // Free-running 100 MHz clock.
    always #5 clock = ~clock;

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One register write; the strobe stays up for exactly one edge.
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clock);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        req <= '0;
        #1;
    endtask

    // One register read; data and valid are judged 1 ns after the taking edge.
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        @(posedge clock);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clock);
        req <= '0;
        #1;
        chk({15'h0000, rdata_valid}, 16'h0001);
        chk(rdata, e);
    endtask

    // Counts recovery clock ticks over a window of cycles.
    task automatic ticks(input int n);
        c = 0;
        repeat (n)
        begin
            @(negedge clock);
            if (recovery_clock_tick === 1'b1)
                c++;
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Power-on values of every register, and an unmapped read.
    task automatic t_reset();
        rd(swt_pkg::ADDR_TRIM, 16'h0000);
        rd(swt_pkg::ADDR_CAL, 16'h0000);
        rd(swt_pkg::ADDR_CDR, 16'h0004);
        rd(7'h3f, 16'h0000);
        chk({10'h000, filter_time_constant}, 16'h0010);
        $display("test reset done");
    endtask

    // Trim fields open only with the unlock code; wake select hidden while locked.
    task automatic t_trim();
        trim_unlock <= 2'h3;
        wr(swt_pkg::ADDR_TRIM, 16'hffff);
        chk({wake_receiver_select, temp_coef_trim, oscillator_coarse_trim}, 16'h1fff);
        rd(swt_pkg::ADDR_TRIM, 16'h4fff);
        for (int u = 0; u < 3; u++)
        begin
            trim_unlock <= u[1:0];
            wr(swt_pkg::ADDR_TRIM, 16'h0000);
            chk({wake_receiver_select, temp_coef_trim, oscillator_coarse_trim}, 16'h1fff);
            rd(swt_pkg::ADDR_TRIM, 16'h0fff);
        end
        trim_unlock <= 2'h3;
        wr(swt_pkg::ADDR_TRIM, 16'h0a35);
        rd(swt_pkg::ADDR_TRIM, 16'h0a35);
        chk({wake_receiver_select, temp_coef_trim, oscillator_coarse_trim}, 16'h0a35);
        $display("test trim done");
    endtask

    // Calibration result captured from the oscillator side; software writes are dropped.
    task automatic t_cal();
        @(posedge clock);
        cal_update <= 1'b1;
        cal_result <= 16'ha55a;
        @(posedge clock);
        cal_update <= 1'b0;
        cal_result <= 16'h1234;
        rd(swt_pkg::ADDR_CAL, 16'ha55a);
        wr(swt_pkg::ADDR_CAL, 16'h0ff0);
        rd(swt_pkg::ADDR_CAL, 16'ha55a);
        $display("test calibration done");
    endtask

    // Recovery control field layout, enable and every clock select code.
    task automatic t_cdr();
        wr(swt_pkg::ADDR_CDR, 16'hffff);
        rd(swt_pkg::ADDR_CDR, 16'h006d);
        for (int s = 0; s < 4; s++)
        begin
            wr(swt_pkg::ADDR_CDR, {9'h000, s[1:0], 5'h05});
            chk({13'h0000, recovery_clock_select, recovery_enable}, {13'h0000, s[1:0], 1'b1});
            ticks(16);
            chk(c[15:0], 16'h0010 >> s);
        end
        wr(swt_pkg::ADDR_CDR, 16'h0004);
        ticks(16);
        chk(c[15:0], 16'h0000);
        // A read in the same cycle as a write returns the old word; an unmapped write is dropped.
        @(posedge clock);
        req <= '{wr: 1'b1, rd: 1'b1, addr: swt_pkg::ADDR_CDR, wdata: 16'h0021};
        @(posedge clock);
        req <= '0;
        #1;
        chk(rdata, 16'h0004);
        wr(7'h3f, 16'hffff);
        rd(swt_pkg::ADDR_CDR, 16'h0021);
        $display("test recovery done");
    endtask

    // Fixed filter codes, then the adaptive bands including an out-of-band gap.
    task automatic t_filter();
        for (int f = 0; f < 3; f++)
        begin
            wr(swt_pkg::ADDR_CDR, {12'h000, f[1:0], 2'h0});
            repeat (2) @(posedge clock);
            #1;
            chk({10'h000, filter_time_constant}, 16'h0008 << f);
        end
        wr(swt_pkg::ADDR_CDR, 16'h000c);
        for (int g = 0; g < 5; g++)
        begin
            @(posedge clock);
            edge_gap_valid <= 1'b1;
            edge_gap_bits  <= (g == 0) ? 4'h3 : (g == 1) ? 4'h4 : (g == 2) ? 4'ha : (g == 3) ? 4'hc : 4'h2;
            @(posedge clock);
            edge_gap_valid <= 1'b0;
            repeat (2) @(posedge clock);
            #1;
            chk({10'h000, filter_time_constant}, (g == 0 || g == 4) ? 16'h0020 : (g == 1) ? 16'h0010 : 16'h0008);
        end
        $display("test filter done");
    endtask

    // Restart keeps configured fields and drops a write; soft reset restores defaults.
    task automatic t_restart();
        wr(swt_pkg::ADDR_TRIM, 16'h4a35);
        wr(swt_pkg::ADDR_CDR, 16'h006d);
        @(posedge clock);
        restart <= 1'b1;
        req     <= '{wr: 1'b1, rd: 1'b0, addr: swt_pkg::ADDR_CDR, wdata: 16'h0000};
        @(posedge clock);
        restart <= 1'b0;
        req     <= '0;
        rd(swt_pkg::ADDR_TRIM, 16'h4a35);
        rd(swt_pkg::ADDR_CDR, 16'h006d);
        @(posedge clock);
        soft_reset <= 1'b1;
        @(posedge clock);
        soft_reset <= 1'b0;
        rd(swt_pkg::ADDR_TRIM, 16'h0000);
        rd(swt_pkg::ADDR_CDR, 16'h0004);
        rd(swt_pkg::ADDR_CAL, 16'h0000);
        chk({10'h000, filter_time_constant}, 16'h0010);
        $display("test restart done");
    endtask

    // Main sequence: reset for six cycles, then every scenario in turn.
    initial
    begin
        clock          = 1'b0;
        rst            = 1'b1;
        soft_reset     = 1'b0;
        restart        = 1'b0;
        trim_unlock    = 2'h0;
        req            = '0;
        cal_update     = 1'b0;
        cal_result     = 16'h0000;
        edge_gap_valid = 1'b0;
        edge_gap_bits  = 4'h0;
        fail_count     = 0;
        compares       = 0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_trim();
        t_cal();
        t_cdr();
        t_filter();
        t_restart();
        close_out();
    end

    // Bounded run: a hang counts as a mismatch and goes to the report.
    initial
    begin
        repeat (20000) @(posedge clock);
        fail_count++;
        close_out();
    end
endmodule
